// file: ccs_clock_switch.sv
// Purpose: oscillator switching, fail-safe fallback and sleep/idle control
// Assumes: oscillator status arrives asynchronously; cpu and wake inputs are on aclk
// Notes: all state lives in one struct registered by a single process
// How it works
// - switching and monitor only when config bit zero
// - disabled: next ignored, current shows initial config
// - disabled: switch request held at zero
// - equal current and next aborts, request cleared
// - valid switch clears lock and fail flags
// - enable new source, wait timer or lock
// - count ten new-clock cycles before handover
// - handover clears request, copies next to current
// - old source off, keep low-power rc/secondary
// - cpu keeps running during the switch
// - monitor on keeps low-power rc running
// - failure raises trap, falls to fast rc
// - fallback keeps pll when pll was used
// - sleep stops the source clock and pll, peripherals and monitor; secondary stays if enabled
// - enabled watchdog cleared on entry, its rc kept
// - wake on interrupt, reset or watchdog
// - sleep wake resumes same clock source
// - idle stops cpu, clocks keep running
// - idle wake resumes cpu 2-4 cycles later
// - interrupt during entry deferred, then wakes
module ccs_clock_switch (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic switch_monitor_config_bit,
    input wire logic [2:0] initial_source_config,
    input wire logic wdt_enabled,
    input wire ccs_pkg::ccs_osc_s osc_in,
    input wire logic power_save_instruction_valid,
    input wire logic power_save_instruction_sleep,
    input wire logic irq_wake,
    input wire logic wdt_timeout,
    output logic [7:0] osc_enable,
    output logic pll_enable,
    output logic [2:0] sys_clk_select,
    output logic clock_fail_trap,
    output logic wdt_clear,
    output logic cpu_run,
    output logic periph_clk_enable,
    output logic wake_by_irq
);
    typedef struct packed {
        ccs_pkg::ccs_sw_e sw;
        ccs_pkg::ccs_pm_e pm;
        logic boot;
        logic [2:0] cur;
        logic [2:0] nxt;
        logic req;
        logic lock;
        logic cf;
        logic sec_en;
        logic key_hi;
        logic key_lo;
        logic [3:0] cnt;
        logic [1:0] wcnt;
        ccs_pkg::ccs_osc_s s1;
        ccs_pkg::ccs_osc_s s2;
        logic mon_d3;
        logic trap;
        logic wclr;
        logic run;
        logic pclk;
        logic wirq;
        logic [7:0] oen;
        logic pen;
        logic aw_h;
        logic [3:0] awa;
        logic w_h;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } ccs_state_s;

    ccs_state_s q, d;

    logic sw_en;
    logic mon_en;
    logic fail_evt;
    logic mon_edge;
    logic src_ready;
    logic do_wr;
    logic valid_sw;
    logic low_power_rc_keep;
    logic [31:0] ctrl_rd;

    // fuse bit low enables both switching and monitor
    assign sw_en = !switch_monitor_config_bit;
    assign mon_en = sw_en && (q.pm != ccs_pkg::PM_SLEEP);
    // only the second flop of each synchroniser is looked at
    assign fail_evt = mon_en && q.s2.osc_fail && !q.trap && (q.cur != ccs_pkg::SRC_FRC)
        && (q.cur != ccs_pkg::SRC_FAST_RC_WITH_PLL);
    assign mon_edge = q.s2.new_clk_mon && !q.mon_d3;
    assign src_ready = q.s2.running[q.nxt] && (!ccs_pkg::ccs_is_xtal(q.nxt) || q.s2.ost_expired)
        && (!ccs_pkg::ccs_uses_pll(q.nxt) || q.lock);
    assign valid_sw = (q.sw == ccs_pkg::SW_CHECK) && (q.nxt != q.cur);
    assign do_wr = q.aw_h && q.w_h && !q.bv;
    assign low_power_rc_keep = (wdt_enabled || mon_en);

    // control register read image
    always_comb
    begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[ccs_pkg::CUR_LSB +: 3] = q.cur;
        ctrl_rd[ccs_pkg::NXT_LSB +: 3] = q.nxt;
        ctrl_rd[ccs_pkg::LOCK_BIT] = q.lock;
        ctrl_rd[ccs_pkg::CF_BIT] = q.cf;
        ctrl_rd[ccs_pkg::SEC_BIT] = q.sec_en;
        ctrl_rd[ccs_pkg::REQ_BIT] = q.req;
    end

    // next-state logic for the whole block
    always_comb
    begin
        d = q;
        d.trap = 1'b0;
        d.wclr = 1'b0;
        // synchronisers for the asynchronous oscillator status
        d.s1 = osc_in;
        d.s2 = q.s1;
        d.mon_d3 = q.s2.new_clk_mon;
        d.boot = 1'b0;

        // axi write channels are taken independently, response after both
        if (!q.aw_h && s_axi_awvalid)
        begin
            d.aw_h = 1'b1;
            d.awa = s_axi_awaddr;
        end
        if (!q.w_h && s_axi_wvalid)
        begin
            d.w_h = 1'b1;
            d.wd = s_axi_wdata;
            d.ws = s_axi_wstrb;
        end
        if (q.bv && s_axi_bready)
        begin
            d.bv = 1'b0;
        end
        if (do_wr)
        begin
            d.aw_h = 1'b0;
            d.w_h = 1'b0;
            d.bv = 1'b1;
            d.br = ccs_pkg::RESP_OKAY;
            // any write disarms both keys, a key write with a matching value then rearms one
            d.key_hi = 1'b0;
            d.key_lo = 1'b0;
            unique case (q.awa)
                ccs_pkg::OFS_CTRL:
                begin
                    if (q.ws[1] && q.key_hi && q.sw == ccs_pkg::SW_IDLE)
                    begin
                        d.nxt = q.wd[ccs_pkg::NXT_LSB +: 3];
                    end
                    if (q.ws[0] && q.key_lo)
                    begin
                        d.sec_en = q.wd[ccs_pkg::SEC_BIT];
                        if (!q.wd[ccs_pkg::CF_BIT])
                        begin
                            d.cf = 1'b0;
                        end
                        if (q.wd[ccs_pkg::REQ_BIT])
                        begin
                            d.req = 1'b1;
                        end
                    end
                end
                ccs_pkg::OFS_KEY:
                begin
                    d.key_hi = q.ws[0] && (q.wd[7:0] == ccs_pkg::KEY_HI);
                    d.key_lo = q.ws[0] && (q.wd[7:0] == ccs_pkg::KEY_LO);
                end
                ccs_pkg::OFS_STAT:
                begin
                    d.br = ccs_pkg::RESP_OKAY;
                end
                default:
                begin
                    d.br = ccs_pkg::RESP_SLVERR;
                end
            endcase
        end

        // axi read: one outstanding, data latched at address acceptance
        if (q.rv && s_axi_rready)
        begin
            d.rv = 1'b0;
        end
        if (!q.rv && s_axi_arvalid)
        begin
            d.rv = 1'b1;
            d.rr = ccs_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                ccs_pkg::OFS_CTRL: d.rd = ctrl_rd;
                ccs_pkg::OFS_KEY: d.rd = 32'h0000_0000;
                ccs_pkg::OFS_STAT: d.rd = {28'h000_0000, sw_en, (q.sw != ccs_pkg::SW_IDLE),
                    (q.pm == ccs_pkg::PM_IDLE), (q.pm == ccs_pkg::PM_SLEEP)};
                default:
                begin
                    d.rd = 32'h0000_0000;
                    d.rr = ccs_pkg::RESP_SLVERR;
                end
            endcase
        end

        // lock flag is set by pll lock, only a valid switch clears it; a set in the same cycle wins
        if (valid_sw)
        begin
            d.lock = 1'b0;
            d.cf = 1'b0;
        end
        if (q.s2.pll_lock)
        begin
            d.lock = 1'b1;
        end

        // switch sequencer
        unique case (q.sw)
            ccs_pkg::SW_IDLE:
            begin
                if (q.req)
                begin
                    d.sw = ccs_pkg::SW_CHECK;
                end
            end
            ccs_pkg::SW_CHECK:
            begin
                if (q.nxt == q.cur)
                begin
                    d.req = 1'b0;
                    d.sw = ccs_pkg::SW_IDLE;
                end
                else
                begin
                    d.sw = ccs_pkg::SW_START;
                end
            end
            ccs_pkg::SW_START:
            begin
                // lets the cleared lock flag settle before it is judged
                d.sw = ccs_pkg::SW_WAIT;
            end
            ccs_pkg::SW_WAIT:
            begin
                if (src_ready)
                begin
                    d.cnt = 4'h0;
                    d.sw = ccs_pkg::SW_COUNT;
                end
            end
            ccs_pkg::SW_COUNT:
            begin
                if (mon_edge)
                begin
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == ccs_pkg::HANDOVER_CYC - 4'h1)
                    begin
                        d.sw = ccs_pkg::SW_DONE;
                    end
                end
            end
            ccs_pkg::SW_DONE:
            begin
                d.cur = q.nxt;
                d.req = 1'b0;
                d.sw = ccs_pkg::SW_IDLE;
            end
            default:
            begin
                d.sw = ccs_pkg::SW_IDLE;
            end
        endcase

        // a failure overrides any switch in flight
        if (fail_evt)
        begin
            d.trap = 1'b1;
            d.cf = 1'b1;
            d.cur = ccs_pkg::ccs_uses_pll(q.cur) ? ccs_pkg::SRC_FAST_RC_WITH_PLL : ccs_pkg::SRC_FRC;
            d.req = 1'b0;
            d.sw = ccs_pkg::SW_IDLE;
        end

        // with switching disabled, the fuse picks the source
        if (!sw_en || q.boot)
        begin
            d.cur = initial_source_config;
            d.nxt = initial_source_config;
        end
        if (!sw_en)
        begin
            d.req = 1'b0;
            d.sw = ccs_pkg::SW_IDLE;
        end

        // power save sequencer; cur is never touched, so sleep wakes on the same source
        unique case (q.pm)
            ccs_pkg::PM_RUN:
            begin
                if (power_save_instruction_valid)
                begin
                    d.pm = ccs_pkg::PM_ENTER;
                    d.run = 1'b0;
                    d.wclr = wdt_enabled;
                end
            end
            ccs_pkg::PM_ENTER:
            begin
                // interrupts are not looked at here, so they wait for entry to finish
                d.pm = power_save_instruction_sleep ? ccs_pkg::PM_SLEEP : ccs_pkg::PM_IDLE;
                d.pclk = !power_save_instruction_sleep;
            end
            ccs_pkg::PM_SLEEP, ccs_pkg::PM_IDLE:
            begin
                if (irq_wake || wdt_timeout)
                begin
                    d.pm = ccs_pkg::PM_WAKE;
                    d.wcnt = 2'h0;
                    d.pclk = 1'b1;
                    d.wirq = irq_wake;
                end
            end
            ccs_pkg::PM_WAKE:
            begin
                d.wcnt = q.wcnt + 2'h1;
                if (q.wcnt == ccs_pkg::RESUME_CYC - 2'h1)
                begin
                    d.run = 1'b1;
                    d.pm = ccs_pkg::PM_RUN;
                end
            end
            default:
            begin
                d.pm = ccs_pkg::PM_RUN;
            end
        endcase
        // the switch never stalls the cpu, only the power save instruction does
        if (q.pm == ccs_pkg::PM_RUN && !power_save_instruction_valid)
        begin
            d.run = 1'b1;
        end

        // oscillator enables: old source drops out once cur moves on
        d.oen = 8'h00;
        if (d.pm != ccs_pkg::PM_SLEEP)
        begin
            d.oen = ccs_pkg::ccs_onehot(d.cur);
            if (d.sw != ccs_pkg::SW_IDLE)
            begin
                d.oen = d.oen | ccs_pkg::ccs_onehot(d.nxt);
            end
        end
        if ((d.pm == ccs_pkg::PM_SLEEP) ? wdt_enabled : low_power_rc_keep)
        begin
            d.oen = d.oen | ccs_pkg::ccs_onehot(ccs_pkg::SRC_LOW_POWER_RC);
        end
        if (d.sec_en)
        begin
            d.oen = d.oen | ccs_pkg::ccs_onehot(ccs_pkg::SRC_SEC);
        end
        d.pen = (d.pm != ccs_pkg::PM_SLEEP) && (ccs_pkg::ccs_uses_pll(d.cur)
            || (d.sw != ccs_pkg::SW_IDLE && ccs_pkg::ccs_uses_pll(d.nxt)));
    end

    // single state register, synchronous active-low reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.sw <= ccs_pkg::SW_IDLE;
            q.pm <= ccs_pkg::PM_RUN;
            q.boot <= 1'b1;
            q.cur <= ccs_pkg::RST_SRC;
            q.nxt <= ccs_pkg::RST_SRC;
            q.run <= 1'b1;
            q.pclk <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs
    assign s_axi_awready = !q.aw_h;
    assign s_axi_wready = !q.w_h;
    assign s_axi_bvalid = q.bv;
    assign s_axi_bresp = q.br;
    assign s_axi_arready = !q.rv;
    assign s_axi_rvalid = q.rv;
    assign s_axi_rdata = q.rd;
    assign s_axi_rresp = q.rr;
    assign osc_enable = q.oen;
    assign pll_enable = q.pen;
    assign sys_clk_select = q.cur;
    assign clock_fail_trap = q.trap;
    assign wdt_clear = q.wclr;
    assign cpu_run = q.run;
    assign periph_clk_enable = q.pclk;
    assign wake_by_irq = q.wirq;

    // checks
    sequence handover_last_s;
        q.sw == ccs_pkg::SW_COUNT && mon_edge && q.cnt == 4'h9 && !fail_evt;
    endsequence

    sequence idle_wake_s;
        q.pm == ccs_pkg::PM_IDLE && irq_wake;
    endsequence

    disabled_req_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !sw_en && !q.boot |=> !q.req && q.cur == $past(initial_source_config))
        else $error("request or source not held while switching disabled");
    redundant_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (q.sw == ccs_pkg::SW_CHECK && q.nxt == q.cur) |=> !q.req && q.sw == ccs_pkg::SW_IDLE)
        else $error("redundant switch not aborted");
    flags_cleared_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (valid_sw && !q.s2.pll_lock && !fail_evt && sw_en) |=> !q.lock && !q.cf)
        else $error("flags not cleared on valid switch");
    handover_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        handover_last_s |=> q.sw == ccs_pkg::SW_DONE ##1 q.sw == ccs_pkg::SW_IDLE)
        else $error("handover not after ten new-clock cycles");
    early_handover_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (q.sw == ccs_pkg::SW_COUNT && q.cnt < 4'h9) |=> q.sw != ccs_pkg::SW_DONE)
        else $error("handover before ten new-clock cycles");
    handover_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (q.sw == ccs_pkg::SW_DONE && !fail_evt && sw_en) |=> q.cur == $past(q.nxt) && !q.req)
        else $error("handover did not copy source or clear request");
    fail_fallback_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fail_evt |=> clock_fail_trap && q.cf
            && q.cur == (ccs_pkg::ccs_uses_pll($past(q.cur)) ? ccs_pkg::SRC_FAST_RC_WITH_PLL : ccs_pkg::SRC_FRC))
        else $error("failure did not trap to fast rc");
    sleep_clocks_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        q.pm == ccs_pkg::PM_SLEEP |-> !periph_clk_enable && !pll_enable
            && osc_enable[ccs_pkg::SRC_LOW_POWER_RC] == wdt_enabled)
        else $error("clocks not stopped in sleep");
    entry_defer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (q.pm == ccs_pkg::PM_RUN && power_save_instruction_valid) |=> wdt_clear == $past(wdt_enabled)
            ##1 (q.pm == ccs_pkg::PM_SLEEP || q.pm == ccs_pkg::PM_IDLE))
        else $error("power save entry not completed first");
    idle_resume_a: assert property (@(posedge aclk) disable iff (!aresetn)
        idle_wake_s |=> !cpu_run ##[2:4] cpu_run)
        else $error("cpu not resumed 2-4 cycles after wake");
    run_in_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (q.sw != ccs_pkg::SW_IDLE && q.pm == ccs_pkg::PM_RUN && !$past(power_save_instruction_valid)) |-> cpu_run)
        else $error("cpu stalled by clock switch");
endmodule : ccs_clock_switch

// file: ccs_pkg.sv
// Purpose: shared constants, types and helpers of the clock control and power save block
// Assumes: 50 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes: source codes and unlock keys are neutral values
package ccs_pkg;
    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_KEY = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;
    // control register field positions
    localparam int CUR_LSB = 12;
    localparam int NXT_LSB = 8;
    localparam int LOCK_BIT = 5;
    localparam int CF_BIT = 3;
    localparam int SEC_BIT = 1;
    localparam int REQ_BIT = 0;
    // unlock keys, values are arbitrary
    localparam logic [7:0] KEY_HI = 8'h3C;
    localparam logic [7:0] KEY_LO = 8'hC3;
    // source codes
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_WITH_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_SEC = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
    // timing: new-clock cycles before handover, cycles before cpu resumes
    localparam logic [3:0] HANDOVER_CYC = 4'hA;
    localparam logic [1:0] RESUME_CYC = 2'h3;
    // reset source and axi response codes
    localparam logic [2:0] RST_SRC = SRC_FRC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SW_IDLE = 3'h0, SW_CHECK = 3'h1, SW_START = 3'h2,
        SW_WAIT = 3'h3, SW_COUNT = 3'h4, SW_DONE = 3'h5
    } ccs_sw_e;

    typedef enum logic [2:0] {
        PM_RUN = 3'h0, PM_ENTER = 3'h1, PM_SLEEP = 3'h2, PM_IDLE = 3'h3, PM_WAKE = 3'h4
    } ccs_pm_e;

    // status from the oscillators: per-source running bits plus shared flags
    typedef struct packed {
        logic [7:0] running;
        logic ost_expired;
        logic pll_lock;
        logic osc_fail;
        logic new_clk_mon;
    } ccs_osc_s;

    function automatic logic ccs_uses_pll(input logic [2:0] code);
        ccs_uses_pll = (code == SRC_FAST_RC_WITH_PLL) || (code == SRC_PRI_PLL);
    endfunction : ccs_uses_pll

    function automatic logic ccs_is_xtal(input logic [2:0] code);
        ccs_is_xtal = (code == SRC_PRI) || (code == SRC_PRI_PLL) || (code == SRC_SEC);
    endfunction : ccs_is_xtal

    function automatic logic [7:0] ccs_onehot(input logic [2:0] code);
        ccs_onehot = 8'h01 << code;
    endfunction : ccs_onehot
endpackage : ccs_pkg

// file: test_clock_switch_failsafe_powersave.sv
// Purpose: self-checking bench for clock switching, fail-safe fallback and power save modes
// Assumes: 50 MHz aclk, synchronous active-low reset, AXI4-Lite register access
// Notes: oscillator status is held as steady levels; the new-clock tap runs free at 1/8 of aclk
module test_clock_switch_failsafe_powersave;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, br;
    logic cfg_bit, wdt_en, pv, ps, irq, wdt_to, trap, wclr, cpu_run, periph, wirq, pll_en;
    logic [2:0] init_src, sel;
    logic [7:0] osc_en;
    ccs_pkg::ccs_osc_s osc;
    int err_total, n_tests, cyc, wclr_cnt, low_cnt, trap_cnt, c0;

    ccs_clock_switch u_ccs_clock_switch (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .switch_monitor_config_bit(cfg_bit), .initial_source_config(init_src), .wdt_enabled(wdt_en),
        .osc_in(osc), .power_save_instruction_valid(pv), .power_save_instruction_sleep(ps), .irq_wake(irq), .wdt_timeout(wdt_to),
        .osc_enable(osc_en), .pll_enable(pll_en), .sys_clk_select(sel), .clock_fail_trap(trap),
        .wdt_clear(wclr), .cpu_run(cpu_run), .periph_clk_enable(periph), .wake_by_irq(wirq));

    // system clock
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // new-clock tap, free running so the handover count always has edges to see
    initial
    begin
        osc.new_clk_mon = 1'b0;
        forever #80 osc.new_clk_mon = ~osc.new_clk_mon;
    end

    // event counters, so short pulses are never missed by the polling tests
    always @(posedge aclk)
    begin
        if (wclr === 1'b1) wclr_cnt <= wclr_cnt + 1;
        if (cpu_run === 1'b0) low_cnt <= low_cnt + 1;
        if (trap === 1'b1) trap_cnt <= trap_cnt + 1;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // holds each channel until its own ready, bready until bvalid is seen
    task axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        br = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task axi_read(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rd = rdata;
        rready <= 1'b0;
    endtask : axi_read

    task set_next(input logic [2:0] src);
        axi_write(ccs_pkg::OFS_KEY, {24'h000000, ccs_pkg::KEY_HI}, 4'hF);
        axi_write(ccs_pkg::OFS_CTRL, {21'h000000, src, 8'h00}, 4'h2);
    endtask : set_next

    task request;
        axi_write(ccs_pkg::OFS_KEY, {24'h000000, ccs_pkg::KEY_LO}, 4'hF);
        // fail flag written as 1 so only the hardware can clear it; secondary kept on
        axi_write(ccs_pkg::OFS_CTRL, 32'h0000000B, 4'h1);
    endtask : request

    // bounded waits; a hang falls through to the value compare after it
    task wait_sel(input logic [2:0] s);
        cyc = 0;
        while (sel !== s && cyc < 3000)
        begin
            @(posedge aclk);
            cyc++;
        end
    endtask : wait_sel

    task wait_run;
        cyc = 0;
        while (cpu_run !== 1'b1 && cyc < 50)
        begin
            @(posedge aclk);
            cyc++;
        end
    endtask : wait_run

    // one power save instruction; mode held through the cycle after the pulse
    task pwr(input logic s, input logic i);
        @(posedge aclk);
        pv <= 1'b1;
        ps <= s;
        irq <= i;
        c0 = wclr_cnt;
        @(posedge aclk);
        pv <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : pwr

    task test_done;
        $display("checks=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #500000;
        err_total++;
        test_done;
    end

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, pv, ps, irq, wdt_to} = '0;
        {awaddr, araddr, wstrb, wdata} = '0;
        {wclr_cnt, low_cnt, trap_cnt, err_total, n_tests} = '0;
        aresetn = 1'b0;
        cfg_bit = 1'b0;
        wdt_en = 1'b1;
        init_src = ccs_pkg::SRC_PRI;
        osc.running = 8'hFF;
        osc.ost_expired = 1'b1;
        osc.pll_lock = 1'b0; // pll unlocked until the pll switch asks for it
        osc.osc_fail = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(ccs_pkg::OFS_CTRL);
        chk(rd[14:12], ccs_pkg::SRC_PRI);
        axi_read(4'hC);
        chk({rresp, rd}, {ccs_pkg::RESP_SLVERR, 32'h00000000});
        axi_write(4'hC, 32'h00000000, 4'hF);
        chk(br, ccs_pkg::RESP_SLVERR);
        // unkeyed write must not move next away from current, so the request is redundant
        set_next(ccs_pkg::SRC_PRI);
        axi_write(ccs_pkg::OFS_CTRL, 32'h00000500, 4'h2);
        request;
        repeat (20) @(posedge aclk);
        axi_read(ccs_pkg::OFS_CTRL);
        chk({rd[14:12], rd[0]}, {ccs_pkg::SRC_PRI, 1'b0});
        // real switch to primary with pll: ten 8-cycle new-clock periods at least
        set_next(ccs_pkg::SRC_PRI_PLL);
        request;
        osc.pll_lock <= 1'b1;
        wait_sel(ccs_pkg::SRC_PRI_PLL);
        chk(cyc > 70 && cyc < 100, 1'b1);
        axi_read(ccs_pkg::OFS_CTRL);
        chk({rd[14:12], rd[5], rd[0]}, {ccs_pkg::SRC_PRI_PLL, 2'h2});
        chk({osc_en[2], osc_en[4], osc_en[5], pll_en, cpu_run}, 5'h0F);
        // oscillator failure while pll in use
        osc.osc_fail <= 1'b1;
        c0 = trap_cnt;
        wait_sel(ccs_pkg::SRC_FAST_RC_WITH_PLL);
        osc.osc_fail <= 1'b0;
        chk(sel, ccs_pkg::SRC_FAST_RC_WITH_PLL);
        @(posedge aclk);
        chk(trap_cnt - c0, 1);
        axi_read(ccs_pkg::OFS_CTRL);
        chk(rd[3], 1'b1);
        set_next(ccs_pkg::SRC_FRC);
        request;
        wait_sel(ccs_pkg::SRC_FRC);
        axi_read(ccs_pkg::OFS_CTRL);
        chk({rd[14:12], rd[3]}, {ccs_pkg::SRC_FRC, 1'b0});
        // sleep, then wake on interrupt
        pwr(1'b1, 1'b0);
        chk({cpu_run, periph, osc_en[0], osc_en[5]}, 4'h1);
        chk(wclr_cnt - c0, 1);
        irq <= 1'b1;
        wait_run;
        chk({sel, wirq, cpu_run}, {ccs_pkg::SRC_FRC, 2'h3});
        irq <= 1'b0;
        // idle, then wake on watchdog time-out
        pwr(1'b0, 1'b0);
        chk({cpu_run, periph}, 2'h1);
        wdt_to <= 1'b1;
        wait_run;
        wdt_to <= 1'b0;
        // one edge to see the wake, 2-4 to resume, one edge to observe it
        chk(cyc >= 4 && cyc <= 6, 1'b1);
        // interrupt coincident with the instruction: entry completes, then wakes
        c0 = low_cnt;
        pwr(1'b0, 1'b1);
        wait_run;
        irq <= 1'b0;
        chk({low_cnt > c0 + 1, wirq, cpu_run}, 3'h7);
        // second reset with switching and monitor disabled by the configuration bit
        aresetn <= 1'b0;
        cfg_bit <= 1'b1;
        init_src <= ccs_pkg::SRC_SEC;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        set_next(ccs_pkg::SRC_FRC);
        request;
        osc.osc_fail <= 1'b1;
        c0 = trap_cnt;
        repeat (120) @(posedge aclk);
        axi_read(ccs_pkg::OFS_CTRL);
        chk({rd[14:12], rd[0], sel}, {ccs_pkg::SRC_SEC, 1'b0, ccs_pkg::SRC_SEC});
        chk(trap_cnt - c0, 0);
        test_done;
    end
endmodule : test_clock_switch_failsafe_powersave
